// >>> rtl/irq_ctl_consts.svh
// Purpose: offsets, field positions, reset values and counts of the interrupt controller
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: definitions only
`ifndef IRQ_CTL_CONSTS_SVH
`define IRQ_CTL_CONSTS_SVH
`define AXI_ADDR_W 12
`define IDX_GEN_MASK 10'h0E0
`define IDX_BLK_MASK 10'h0E1
`define IDX_VECTOR 10'h0E2
`define IDX_FLAGS 10'h0E3
`define IDX_PENDING 10'h0E4
`define MASK_RESET 8'h00
`define FLAGS_RESET 8'h00
`define FLAG_IE_BIT 0
`define GEN_MONITOR_BIT 0
`define GEN_COLUMN_LSB 1
`define GEN_PIN_BIT 5
`define GEN_SLEEP_BIT 6
`define GEN_MASK_USED 8'h7F
`define NUM_SOURCES 15
`define SRC_MONITOR 0
`define SRC_BLOCK_LSB 1
`define SRC_COLUMN_LSB 9
`define SRC_PIN 13
`define SRC_SLEEP 14
`define VEC_STEP 4
`define CALL_CYCLES 4'd13
`define CALL_LAST 4'd12
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> rtl/irq_ctl_pkg.sv
// Purpose: types of the interrupt controller
// Assumes: constants come from irq_ctl_consts.svh
// Notes: nothing here is imported
`include "irq_ctl_consts.svh"
package irq_ctl_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_call = 2'b01
    } call_state_type;

    typedef struct packed {
        logic awvalid;
        logic [`AXI_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`AXI_ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_type;

    typedef struct packed {
        logic awready;
        logic aw_held;
        logic [9:0] aw_index;
        logic wready;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] gen_mask;
        logic [7:0] blk_mask;
        logic [7:0] flags;
        logic [`NUM_SOURCES-1:0] pending;
        logic [`NUM_SOURCES-1:0] src_prev;
        call_state_type state;
        logic [3:0] cnt;
        logic [15:0] pc_save;
        logic irq;
        logic push_valid;
        logic [7:0] push_data;
        logic pc_load;
        logic [15:0] pc_vector;
    } ctl_state_type;
endpackage

// >>> rtl/priority_interrupt_controller.sv
// Purpose: fixed-priority interrupt controller with automatic call sequencer
// Assumes: all sources and the core run on i_clk_sys; AXI4-Lite register access
// Notes: one state struct, two comb processes, one clocked process
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "irq_ctl_consts.svh"

// Notes on behaviour
// - fifteen sources: pins, supply monitor, sleep timer, eight blocks, four columns.
// - each source has one enable bit; writing one enables it.
// - global enable in flags gates all; set lets only unmasked sources request.
// - reset clears both mask registers and the global enable.
// - reading the vector register returns the highest-priority unmasked pending vector.
// - any write to the vector register clears all pending flags.
// - masking the only pending source before the vector load at the end of the call yields vector zero.
// - every source has its own pending flip-flop.
// - pending stays until serviced, reset, or vector register write.
// - pending raises request only with its mask bit and global enable set.
// - pin contributes only when its enable and type configuration allow it.
// - column interrupt occurs only when its source selection is configured.
// - acknowledge runs a 13-cycle call pushing PC high, PC low, flags.
// - return from interrupt restores flags, hence the global enable.
// - lowest priority number among pending sources is serviced first.
// - after flags are pushed the flags register clears, blocking interrupts.
// - each of the fifteen sources has its own distinct vector.
// - vectors four bytes apart; monitor 0x04 to sleep 0x3C.
// - pin outputs ORed into one rising-edge pending input.
// - general mask: monitor 0, columns 1-4, pins 5, sleep 6, 7 reserved.
// - block mask: first block bit 0 through eighth block bit 7.
module priority_interrupt_controller #(
    parameter int NUM_PINS = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire irq_ctl_pkg::axil_req_type i_axi,
    output irq_ctl_pkg::axil_rsp_type o_axi,
    input wire logic [NUM_PINS-1:0] i_pin_irq_out,
    input wire logic [NUM_PINS-1:0] i_pin_cfg_ok,
    input wire logic i_src_monitor,
    input wire logic i_src_sleep,
    input wire logic [7:0] i_src_block,
    input wire logic [3:0] i_src_column,
    input wire logic [3:0] i_column_sel_ok,
    input wire logic i_ack_allow,
    input wire logic [15:0] i_pc,
    input wire logic i_return_from_irq,
    input wire logic [7:0] i_return_from_irq_flags,
    output logic o_irq,
    output logic o_call_busy,
    output logic o_push_valid,
    output logic [7:0] o_push_data,
    output logic o_pc_load,
    output logic [15:0] o_pc_vector,
    output logic [7:0] o_flags
);

    if (NUM_PINS < 1 || NUM_PINS > 64) begin : g_check
        $error("NUM_PINS must lie between 1 and 64");
    end

    irq_ctl_pkg::ctl_state_type s_q;
    irq_ctl_pkg::ctl_state_type s_d;

    logic [`NUM_SOURCES-1:0] src_now;
    logic [`NUM_SOURCES-1:0] src_set;
    logic [`NUM_SOURCES-1:0] mask_vec;
    logic [`NUM_SOURCES-1:0] live;
    logic [`NUM_SOURCES-1:0] svc_onehot;
    logic [7:0] top_vec;
    logic pin_any;
    logic wr_fire;
    logic rd_fire;
    logic clear_all;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // lowest index wins, vector is index plus one times step
    function automatic logic [7:0] top_vector(input logic [`NUM_SOURCES-1:0] req);
        logic [7:0] v;
        v = 8'h00;
        for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
            if (req[i]) begin
                v = 8'((i + 1) * `VEC_STEP);
            end
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // source gathering

    always_comb begin
        pin_any = |(i_pin_irq_out & i_pin_cfg_ok);
        src_now = '0;
        src_now[`SRC_MONITOR] = i_src_monitor;
        src_now[`SRC_BLOCK_LSB +: 8] = i_src_block;
        src_now[`SRC_COLUMN_LSB +: 4] = i_src_column & i_column_sel_ok;
        src_now[`SRC_PIN] = pin_any;
        src_now[`SRC_SLEEP] = i_src_sleep;
        // rising edge sets pending
        src_set = src_now & ~s_q.src_prev;
        mask_vec = '0;
        mask_vec[`SRC_MONITOR] = s_q.gen_mask[`GEN_MONITOR_BIT];
        mask_vec[`SRC_BLOCK_LSB +: 8] = s_q.blk_mask;
        mask_vec[`SRC_COLUMN_LSB +: 4] = s_q.gen_mask[`GEN_COLUMN_LSB +: 4];
        mask_vec[`SRC_PIN] = s_q.gen_mask[`GEN_PIN_BIT];
        mask_vec[`SRC_SLEEP] = s_q.gen_mask[`GEN_SLEEP_BIT];
        live = s_q.pending & mask_vec;
        top_vec = top_vector(live);
        svc_onehot = live & `NUM_SOURCES'(~live + `NUM_SOURCES'(1));
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        clear_all = 1'b0;
        s_d.src_prev = src_now;
        s_d.push_valid = 1'b0;
        s_d.pc_load = 1'b0;

        // write address and data taken in either order
        if (i_axi.awvalid && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_index = i_axi.awaddr[11:2];
        end
        if (i_axi.wvalid && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.w_byte = i_axi.wdata[7:0];
            s_d.w_lane0 = i_axi.wstrb[0];
        end
        if (s_q.bvalid && i_axi.bready) begin
            s_d.bvalid = 1'b0;
        end
        wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
        if (wr_fire) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `RESP_OKAY;
            case (s_q.aw_index)
                `IDX_GEN_MASK: begin
                    if (s_q.w_lane0) begin
                        s_d.gen_mask = s_q.w_byte & `GEN_MASK_USED;
                    end
                end
                `IDX_BLK_MASK: begin
                    if (s_q.w_lane0) begin
                        s_d.blk_mask = s_q.w_byte;
                    end
                end
                `IDX_VECTOR: begin
                    clear_all = 1'b1;
                end
                `IDX_FLAGS: begin
                    if (s_q.w_lane0) begin
                        s_d.flags = s_q.w_byte;
                    end
                end
                `IDX_PENDING: begin
                end
                default: begin
                    s_d.bresp = `RESP_SLVERR;
                end
            endcase
        end
        s_d.awready = !s_d.aw_held && !s_d.bvalid;
        s_d.wready = !s_d.w_held && !s_d.bvalid;

        // read channel
        if (s_q.rvalid && i_axi.rready) begin
            s_d.rvalid = 1'b0;
        end
        rd_fire = i_axi.arvalid && s_q.arready;
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `RESP_OKAY;
            s_d.rdata = 32'h0000_0000;
            case (i_axi.araddr[11:2])
                `IDX_GEN_MASK: s_d.rdata[7:0] = s_q.gen_mask;
                `IDX_BLK_MASK: s_d.rdata[7:0] = s_q.blk_mask;
                `IDX_VECTOR: s_d.rdata[7:0] = top_vec;
                `IDX_FLAGS: s_d.rdata[7:0] = s_q.flags;
                `IDX_PENDING: s_d.rdata[`NUM_SOURCES-1:0] = s_q.pending;
                default: s_d.rresp = `RESP_SLVERR;
            endcase
        end
        s_d.arready = !s_d.rvalid;

        // return from interrupt restores saved flags
        if (i_return_from_irq) begin
            s_d.flags = i_return_from_irq_flags;
        end

        // pending clear, set wins over clear
        if (clear_all) begin
            s_d.pending = '0;
        end

        // automatic call sequencer
        case (s_q.state)
            irq_ctl_pkg::st_idle: begin
                if (s_q.irq && i_ack_allow && !i_return_from_irq) begin
                    s_d.state = irq_ctl_pkg::st_call;
                    s_d.cnt = 4'd0;
                    s_d.pc_save = i_pc;
                end
            end
            irq_ctl_pkg::st_call: begin
                s_d.cnt = s_q.cnt + 4'd1;
                case (s_q.cnt)
                    4'd0: begin
                        s_d.push_valid = 1'b1;
                        s_d.push_data = s_q.pc_save[15:8];
                    end
                    4'd1: begin
                        s_d.push_valid = 1'b1;
                        s_d.push_data = s_q.pc_save[7:0];
                    end
                    4'd2: begin
                        s_d.push_valid = 1'b1;
                        s_d.push_data = s_q.flags;
                    end
                    4'd3: begin
                        s_d.flags = `FLAGS_RESET;
                    end
                    `CALL_LAST: begin
                        // vector chosen now; masked-out pending gives zero
                        s_d.pc_load = 1'b1;
                        s_d.pc_vector = {8'h00, top_vec};
                        s_d.pending = s_d.pending & ~svc_onehot;
                        s_d.state = irq_ctl_pkg::st_idle;
                        s_d.cnt = 4'd0;
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                s_d.state = irq_ctl_pkg::st_idle;
            end
        endcase

        s_d.pending = s_d.pending | src_set;
        s_d.irq = s_d.flags[`FLAG_IE_BIT]
                  && ((s_d.pending & mask_vec) != '0)
                  && (s_d.state == irq_ctl_pkg::st_idle);
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.gen_mask <= `MASK_RESET;
            s_q.blk_mask <= `MASK_RESET;
            s_q.flags <= `FLAGS_RESET;
            s_q.state <= irq_ctl_pkg::st_idle;
            s_q.bresp <= `RESP_OKAY;
            s_q.rresp <= `RESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_axi.awready = s_q.awready;
    assign o_axi.wready = s_q.wready;
    assign o_axi.bvalid = s_q.bvalid;
    assign o_axi.bresp = s_q.bresp;
    assign o_axi.arready = s_q.arready;
    assign o_axi.rvalid = s_q.rvalid;
    assign o_axi.rdata = s_q.rdata;
    assign o_axi.rresp = s_q.rresp;
    assign o_irq = s_q.irq;
    assign o_call_busy = (s_q.state == irq_ctl_pkg::st_call);
    assign o_push_valid = s_q.push_valid;
    assign o_push_data = s_q.push_data;
    assign o_pc_load = s_q.pc_load;
    assign o_pc_vector = s_q.pc_vector;
    assign o_flags = s_q.flags;

endmodule

// >>> sim/cpu_core_model.sv
// Purpose: core that acknowledges calls and returns from them
// Assumes: i_hold delays instruction boundaries
// Notes: keeps the last three stacked bytes
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_hold,
    input wire logic i_do_return_from_irq,
    input wire logic i_push_valid,
    input wire logic [7:0] i_push_data,
    input wire logic i_pc_load,
    input wire logic [15:0] i_pc_vector,
    output logic o_ack_allow,
    output logic [15:0] o_pc,
    output logic o_return_from_irq,
    output logic [7:0] o_return_from_irq_flags,
    output logic [23:0] o_frame,
    output logic [15:0] o_vector
);
    assign o_pc = 16'hC35A;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ack_allow <= 1'b0;
            o_return_from_irq <= 1'b0;
            o_return_from_irq_flags <= 8'h00;
            o_frame <= 24'h000000;
            o_vector <= 16'h0000;
        end else begin
            o_ack_allow <= !i_hold;
            o_return_from_irq <= i_do_return_from_irq;
            o_return_from_irq_flags <= o_frame[7:0];
            if (i_push_valid) begin
                o_frame <= {o_frame[15:0], i_push_data};
            end
            if (i_pc_load) begin
                o_vector <= i_pc_vector;
            end
        end
    end
endmodule

// >>> sim/irq_ctl_asserts.sv
// Purpose: port assertions of the interrupt controller
// Assumes: core model holds i_pc steady
// Notes: bound to the top module below
`timescale 1ns/1ps
module irq_ctl_asserts (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire irq_ctl_pkg::axil_req_type i_axi,
    input wire irq_ctl_pkg::axil_rsp_type o_axi,
    input wire logic i_ack_allow,
    input wire logic [15:0] i_pc,
    input wire logic i_return_from_irq,
    input wire logic [7:0] i_return_from_irq_flags,
    input wire logic o_irq,
    input wire logic o_call_busy,
    input wire logic o_push_valid,
    input wire logic [7:0] o_push_data,
    input wire logic o_pc_load,
    input wire logic [15:0] o_pc_vector,
    input wire logic [7:0] o_flags
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_pushes;
        o_push_valid && o_push_data == $past(i_pc[15:8], 2)
        ##1 o_push_valid && o_push_data == $past(i_pc[7:0], 3) ##1 o_push_valid;
    endsequence
    sequence s_call_end;
        o_call_busy ##1 (!o_call_busy && o_pc_load);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    AST_CALL_START: assert property (o_irq && i_ack_allow && !i_return_from_irq |=> $rose(o_call_busy))
        else $error("call did not start");
    AST_PUSH_ORDER: assert property ($rose(o_call_busy) |=> s_pushes)
        else $error("stack bytes wrong");
    AST_CALL_LEN: assert property ($rose(o_call_busy) |-> ##12 s_call_end)
        else $error("call length wrong");
    AST_FLAGS_CLEAR: assert property ($rose(o_call_busy) |=> o_push_valid [*3] ##[0:2] o_flags == 8'h00)
        else $error("flags not cleared");
    AST_NO_IRQ_IN_CALL: assert property (o_call_busy |-> !o_irq)
        else $error("request during call");
    AST_IRQ_NEEDS_IE: assert property (o_irq |-> o_flags[0] || $past(o_flags[0]))
        else $error("request without global enable");
    AST_VECTOR_ALIGNED: assert property (o_pc_load |-> o_pc_vector[1:0] == 2'b00 && o_pc_vector <= 16'h003C)
        else $error("vector out of table");
    AST_RETURN_FROM_IRQ_FLAGS: assert property (i_return_from_irq && !o_call_busy |=> o_flags == $past(i_return_from_irq_flags))
        else $error("flags not restored");
    AST_RDATA_HOLD: assert property (o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
        else $error("read data not held");
endmodule

bind priority_interrupt_controller irq_ctl_asserts irq_ctl_asserts_i (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_axi(i_axi), .o_axi(o_axi), .i_ack_allow(i_ack_allow), .i_pc(i_pc),
    .i_return_from_irq(i_return_from_irq), .i_return_from_irq_flags(i_return_from_irq_flags), .o_irq(o_irq), .o_call_busy(o_call_busy),
    .o_push_valid(o_push_valid), .o_push_data(o_push_data), .o_pc_load(o_pc_load),
    .o_pc_vector(o_pc_vector), .o_flags(o_flags));

// >>> sim/tb_priority_interrupt_controller.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: byte address is four times the register index
// Notes: sources pulse one cycle, except pin 1, which is held high for the pin_or check
`timescale 1ns/1ps
`include "irq_ctl_consts.svh"
module tb_priority_interrupt_controller;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    irq_ctl_pkg::axil_req_type req = '0;
    irq_ctl_pkg::axil_rsp_type rsp;
    logic [14:0] src = 15'h0000;
    logic [7:0] pinx = 8'h00;
    logic [7:0] pin_ok = 8'hFF;
    logic [3:0] col_ok = 4'hF;
    logic hold = 1'b0;
    logic do_return_from_irq = 1'b0;
    logic ack_allow, return_from_irq, irq, busy, push_valid, pc_load;
    logic [15:0] pc, pc_vector, vector;
    logic [7:0] return_from_irq_flags, push_data, flags;
    logic [23:0] frame;
    logic [31:0] rd;
    logic [1:0] resp;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] vec_tab [15] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
        8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
    priority_interrupt_controller #(.NUM_PINS(8)) priority_interrupt_controller_i (
        .i_clk_sys(clk_sys), .i_rst(rst), .i_axi(req), .o_axi(rsp),
        .i_pin_irq_out({pinx[7:1], pinx[0] | src[13]}), .i_pin_cfg_ok(pin_ok),
        .i_src_monitor(src[0]), .i_src_sleep(src[14]), .i_src_block(src[8:1]),
        .i_src_column(src[12:9]), .i_column_sel_ok(col_ok), .i_ack_allow(ack_allow), .i_pc(pc),
        .i_return_from_irq(return_from_irq), .i_return_from_irq_flags(return_from_irq_flags), .o_irq(irq), .o_call_busy(busy),
        .o_push_valid(push_valid), .o_push_data(push_data), .o_pc_load(pc_load),
        .o_pc_vector(pc_vector), .o_flags(flags));
    cpu_core_model cpu_core_model_i (.i_clk_sys(clk_sys), .i_rst(rst), .i_hold(hold),
        .i_do_return_from_irq(do_return_from_irq), .i_push_valid(push_valid), .i_push_data(push_data),
        .i_pc_load(pc_load), .i_pc_vector(pc_vector), .o_ack_allow(ack_allow), .o_pc(pc),
        .o_return_from_irq(return_from_irq), .o_return_from_irq_flags(return_from_irq_flags), .o_frame(frame), .o_vector(vector));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        req.awvalid <= 1'b1;
        req.awaddr <= {idx, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        resp = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdr(input logic [9:0] idx);
        req.arvalid <= 1'b1;
        req.araddr <= {idx, 2'b00};
        req.rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic pulse(input int i);
        src[i] <= 1'b1;
        @(posedge clk_sys);
        src[i] <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wait_load;
        for (int k = 0; k < 40 && !pc_load; k++) @(posedge clk_sys);
        @(posedge clk_sys);
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdr(`IDX_GEN_MASK); chk("gen_rst", rd, 32'h0);
        rdr(`IDX_BLK_MASK); chk("blk_rst", rd, 32'h0);
        rdr(`IDX_FLAGS); chk("flags_rst", rd, 32'h0);
        wr(`IDX_GEN_MASK, 32'hFFFFFFFF);
        rdr(`IDX_GEN_MASK); chk("gen_mask", rd, 32'h7F);
        wr(`IDX_BLK_MASK, 32'h000000FF);
        for (int i = 0; i < 15; i++) begin
            pulse(i);
            rdr(`IDX_VECTOR); chk("vector", rd, {24'h0, vec_tab[i]});
            rdr(`IDX_PENDING); chk("pending", rd, 32'h1 << i);
            chk("irq_off", {31'h0, irq}, 32'h0);
            wr(`IDX_VECTOR, 32'h0000005A);
            rdr(`IDX_PENDING); chk("cleared", rd, 32'h0);
        end
        src <= 15'h0810;
        @(posedge clk_sys);
        src <= 15'h0000;
        @(posedge clk_sys);
        rdr(`IDX_VECTOR); chk("prio", rd, 32'h14);
        hold <= 1'b1;
        wr(`IDX_FLAGS, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk("irq_on", {31'h0, irq}, 32'h1);
        hold <= 1'b0;
        wait_load();
        chk("vec1", {16'h0, vector}, 32'h14);
        chk("frame", {8'h0, frame}, 32'h00C35A01);
        chk("flags_call", {24'h0, flags}, 32'h0);
        rdr(`IDX_PENDING); chk("left", rd, 32'h800);
        do_return_from_irq <= 1'b1;
        @(posedge clk_sys);
        do_return_from_irq <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("flags_return_from_irq", {24'h0, flags}, 32'h1);
        wait_load();
        chk("vec2", {16'h0, vector}, 32'h30);
        do_return_from_irq <= 1'b1;
        @(posedge clk_sys);
        do_return_from_irq <= 1'b0;
        repeat (3) @(posedge clk_sys);
        pulse(14);
        for (int k = 0; k < 20 && !busy; k++) @(posedge clk_sys);
        wr(`IDX_GEN_MASK, 32'h0);
        wait_load();
        chk("zero_vec", {16'h0, vector}, 32'h0);
        wr(`IDX_FLAGS, 32'h0);
        wr(`IDX_GEN_MASK, 32'h7F);
        wr(`IDX_VECTOR, 32'h0);
        pinx[1] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rdr(`IDX_PENDING); chk("pin_or", rd, 32'h2000);
        wr(`IDX_VECTOR, 32'h0);
        pulse(13);
        rdr(`IDX_PENDING); chk("pin_masked", rd, 32'h0);
        pinx <= 8'h00;
        pin_ok <= 8'hFD;
        col_ok <= 4'hE;
        @(posedge clk_sys);
        pinx[1] <= 1'b1;
        src[9] <= 1'b1;
        @(posedge clk_sys);
        pinx[1] <= 1'b0;
        src[9] <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rdr(`IDX_PENDING); chk("cfg_gate", rd, 32'h0);
        wr(10'h0FF, 32'h1); chk("unmapped_w", {30'h0, resp}, 32'h2);
        rdr(10'h0FF); chk("unmapped_r", {30'h0, resp}, 32'h2);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdr(`IDX_GEN_MASK); chk("gen_rst2", rd, 32'h0);
        print_verdict();
    end
endmodule
